// ==== rtl/cmp_if.sv ====
`timescale 1ns/1ps

interface cmp_if;
  logic              valid;
  lsr_pkg::chan_t    chan;
  logic [9:0]        result;
  logic [7:0]        highLim;
  logic [7:0]        lowLim;
  logic              signedCmp;
  logic              outValid;
  lsr_pkg::chan_t    outChan;
  logic              aboveHigh;
  logic              atOrBelowLow;

  modport req (
    output valid, chan, result, highLim, lowLim, signedCmp,
    input  outValid, outChan, aboveHigh, atOrBelowLow
  );
  modport cmp (
    input  valid, chan, result, highLim, lowLim, signedCmp,
    output outValid, outChan, aboveHigh, atOrBelowLow
  );
endinterface : cmp_if

// ==== rtl/limit_compare.sv ====
`timescale 1ns/1ps
`include "lsr_regs.svh"

module limit_compare (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Comparison request and verdict
  cmp_if.cmp        cmp
);

  lsr_pkg::cmp_state_t state_q;
  lsr_pkg::cmp_state_t state_d;
  logic [7:0]          msbPart;

  // Limits are 8 bits wide, so only the upper result bits take part
  assign msbPart = cmp.result[`RESULT_W-1:`RESULT_W-`LIMIT_W];

  always_comb begin
    state_d       = state_q;
    state_d.valid = cmp.valid;
    if (cmp.valid) begin
      state_d.chan = cmp.chan;
      if (cmp.signedCmp) begin
        state_d.aboveHigh    = $signed(msbPart) > $signed(cmp.highLim);
        state_d.atOrBelowLow = $signed(msbPart) <= $signed(cmp.lowLim);
      end else begin
        state_d.aboveHigh    = msbPart > cmp.highLim;
        state_d.atOrBelowLow = msbPart <= cmp.lowLim;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= '{valid: 1'b0, chan: lsr_pkg::CH_DIE, aboveHigh: 1'b0, atOrBelowLow: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign cmp.outValid     = state_q.valid;
  assign cmp.outChan      = state_q.chan;
  assign cmp.aboveHigh    = state_q.aboveHigh;
  assign cmp.atOrBelowLow = state_q.atOrBelowLow;

endmodule : limit_compare

// ==== rtl/limit_status_and_result_lsbs.sv ====
// What this block does
// R1: A read of a status register clears only flags whose condition has recovered.
// R2: Software reset clears both status registers to zero.
// R3: Unmasked set status flags drive the interrupt output active.
// R4: Status 1 bit 0 sets when die temperature is above its high limit.
// R5: Status 1 bit 1 sets when die temperature is at or below its low limit.
// R6: Status 1 bit 2 flags external high, or analog input one outside limits.
// R7: Status 1 bit 3 sets when external temperature is at or below low limit.
// R8: Status 1 bit 4 sets on an open or shorted external sensing diode.
// R9: Status 1 bits 5 to 7 flag analog inputs two to four outside limits.
// R10: Status 2 bits 0 to 3 flag analog inputs five to eight outside limits.
// R11: Status 2 bit 4 flags supply outside limits; bits 5 to 7 read zero.
// R12: Low-order register bits 1:0 hold the two die temperature LSBs.
// R13: Low-order register bits 3:2 hold the two supply LSBs.
// R14: All defined status and low-order bits power up as zero.
// R15: A set flag stays set until a qualifying read or software reset.
// R16: Reading the low-order register first freezes the supply and die MSB registers.
// R17: Reading either frozen MSB register releases both; MSB reads never freeze LSBs.
// R18: Configuration 1 bits 2:1 choose external sensor or analog input one.
`timescale 1ns/1ps
`include "lsr_regs.svh"

module limit_status_and_result_lsbs (
  // Clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 arst_n,
  // Results from the conversion engine
  input  wire logic                                 convValid,
  input  wire lsr_pkg::chan_t                       convChan,
  input  wire logic [`RESULT_W-1:0]                 convResult,
  input  wire logic                                 diodeFault,
  // Limits, masks and configuration held elsewhere
  input  wire logic [`CHAN_COUNT-1:0][`LIMIT_W-1:0] limHigh,
  input  wire logic [`CHAN_COUNT-1:0][`LIMIT_W-1:0] limLow,
  input  wire logic [7:0]                           maskFirst,
  input  wire logic [7:0]                           maskSecond,
  input  wire logic [1:0]                           pairSel,
  input  wire logic                                 softReset,
  // Register read port
  input  wire logic                                 regRd,
  input  wire logic [7:0]                           regAddr,
  output logic [7:0]                                regRdData,
  // Status outputs
  output logic                                      intActive,
  output logic                                      msbFrozen
);

  lsr_pkg::top_state_t state_q;
  lsr_pkg::top_state_t state_d;

  cmp_if cmpBus ();

  logic       extMode;
  logic [7:0] hitFirst;
  logic [7:0] hitSecond;
  logic [7:0] touchFirst;
  logic [7:0] touchSecond;
  logic [7:0] lowBits;
  logic       rdFirst;
  logic       rdSecond;
  logic       rdLow;
  logic       rdMsb;

  // Pair selection decode, used for comparison sign and flag mapping
  function automatic logic pairIsExternal(input logic [1:0] sel);
    pairIsExternal = (sel == `CFG_PAIR_EXT);
  endfunction : pairIsExternal

  function automatic logic addrHit(input logic [7:0] a, input logic [7:0] target);
    addrHit = (a == target);
  endfunction : addrHit

  assign extMode  = pairIsExternal(pairSel); // R18
  assign rdFirst  = regRd && addrHit(regAddr, `ADDR_STATUS_FIRST);
  assign rdSecond = regRd && addrHit(regAddr, `ADDR_STATUS_SECOND);
  assign rdLow    = regRd && addrHit(regAddr, `ADDR_LOW_BITS);
  assign rdMsb    = regRd && (addrHit(regAddr, `ADDR_SUPPLY_MSB) ||
                              addrHit(regAddr, `ADDR_DIE_MSB));

  // Comparison request; temperatures are twos complement
  assign cmpBus.valid     = convValid;
  assign cmpBus.chan      = convChan;
  assign cmpBus.result    = convResult;
  assign cmpBus.highLim   = limHigh[convChan];
  assign cmpBus.lowLim    = limLow[convChan];
  assign cmpBus.signedCmp = (convChan == lsr_pkg::CH_DIE) ||
                            (convChan == lsr_pkg::CH_EXT_A1 && extMode); // R18

  limit_compare u_cmp (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .cmp     (cmpBus.cmp)
  );

  // Map the verdict of one channel onto the flag bits it owns
  always_comb begin
    hitFirst    = 8'h00;
    hitSecond   = 8'h00;
    touchFirst  = 8'h00;
    touchSecond = 8'h00;
    if (cmpBus.outValid) begin
      case (cmpBus.outChan)
        lsr_pkg::CH_DIE: begin
          touchFirst[`S1_DIE_HIGH] = 1'b1;
          touchFirst[`S1_DIE_LOW]  = 1'b1;
          hitFirst[`S1_DIE_HIGH]   = cmpBus.aboveHigh; // R4
          hitFirst[`S1_DIE_LOW]    = cmpBus.atOrBelowLow; // R5
        end
        lsr_pkg::CH_EXT_A1: begin
          touchFirst[`S1_PAIR_HIGH] = 1'b1;
          touchFirst[`S1_EXT_LOW]   = 1'b1;
          if (extMode) begin
            hitFirst[`S1_PAIR_HIGH] = cmpBus.aboveHigh; // R6
            hitFirst[`S1_EXT_LOW]   = cmpBus.atOrBelowLow; // R7
          end else begin
            hitFirst[`S1_PAIR_HIGH] = cmpBus.aboveHigh || cmpBus.atOrBelowLow; // R6
          end
        end
        lsr_pkg::CH_A2, lsr_pkg::CH_A3, lsr_pkg::CH_A4: begin
          touchFirst[`S1_ANALOG_INPUT_TWO + (cmpBus.outChan - lsr_pkg::CH_A2)] = 1'b1;
          hitFirst[`S1_ANALOG_INPUT_TWO + (cmpBus.outChan - lsr_pkg::CH_A2)] =
            cmpBus.aboveHigh || cmpBus.atOrBelowLow; // R9
        end
        lsr_pkg::CH_A5, lsr_pkg::CH_A6, lsr_pkg::CH_A7, lsr_pkg::CH_A8: begin
          touchSecond[`S2_ANALOG_INPUT_FIVE + (cmpBus.outChan - lsr_pkg::CH_A5)] = 1'b1;
          hitSecond[`S2_ANALOG_INPUT_FIVE + (cmpBus.outChan - lsr_pkg::CH_A5)] =
            cmpBus.aboveHigh || cmpBus.atOrBelowLow; // R10
        end
        lsr_pkg::CH_SUPPLY: begin
          touchSecond[`S2_SUPPLY] = 1'b1;
          hitSecond[`S2_SUPPLY]   = cmpBus.aboveHigh || cmpBus.atOrBelowLow; // R11
        end
        default: begin
          hitFirst = 8'h00;
        end
      endcase
    end
    // Diode fault is a level from the engine, meaningful only with the sensor fitted
    touchFirst[`S1_DIODE_FAULT] = 1'b1;
    hitFirst[`S1_DIODE_FAULT]   = diodeFault && extMode; // R8
    hitSecond = hitSecond & `S2_DEFINED_MASK; // R11
  end

  assign lowBits = {4'h0,
                    state_q.supply[1:0],
                    state_q.dieTemp[1:0]};

  always_comb begin
    state_d = state_q;

    // Current out-of-limit levels, refreshed by each verdict
    state_d.condFirst  = (state_q.condFirst & ~touchFirst) | hitFirst;
    state_d.condSecond = (state_q.condSecond & ~touchSecond) | hitSecond;

    // Clear first, then set, so a fresh event in the clear cycle survives
    if (softReset) begin
      state_d.statusFirst  = `RST_STATUS; // R2
      state_d.statusSecond = `RST_STATUS; // R2
    end else begin
      if (rdFirst) begin
        state_d.statusFirst = state_q.statusFirst & state_q.condFirst; // R1
      end
      if (rdSecond) begin
        state_d.statusSecond = state_q.statusSecond & state_q.condSecond; // R1
      end
    end
    state_d.statusFirst  = state_d.statusFirst | hitFirst; // R15
    state_d.statusSecond = state_d.statusSecond | hitSecond; // R15

    state_d.intActive = |(state_d.statusFirst & ~maskFirst) ||
                        |(state_d.statusSecond & ~maskSecond); // R3

    // Result capture; the low-order bits always follow the latest conversion
    if (convValid && convChan == lsr_pkg::CH_DIE) begin
      state_d.dieTemp = convResult; // R12
    end
    if (convValid && convChan == lsr_pkg::CH_SUPPLY) begin
      state_d.supply = convResult; // R13
    end

    // MSB copies track the results only while not frozen
    case (state_q.frz)
      lsr_pkg::MSB_FREE: begin
        if (rdLow) begin
          state_d.frz = lsr_pkg::MSB_FROZEN; // R16
        end
      end
      lsr_pkg::MSB_FROZEN: begin
        if (rdMsb) begin
          state_d.frz = lsr_pkg::MSB_FREE; // R17
        end
      end
      default: begin
        state_d.frz = lsr_pkg::MSB_FREE;
      end
    endcase
    if (state_d.frz == lsr_pkg::MSB_FREE) begin
      state_d.dieMsbHeld    = state_d.dieTemp[`RESULT_W-1:`RESULT_W-`LIMIT_W];
      state_d.supplyMsbHeld = state_d.supply[`RESULT_W-1:`RESULT_W-`LIMIT_W];
    end

    // Read data; the frozen copy is what an MSB read returns
    if (regRd) begin
      case (regAddr)
        `ADDR_STATUS_FIRST:  state_d.rdData = state_q.statusFirst;
        `ADDR_STATUS_SECOND: state_d.rdData = state_q.statusSecond & `S2_DEFINED_MASK; // R11
        `ADDR_LOW_BITS:      state_d.rdData = lowBits; // R12
        `ADDR_SUPPLY_MSB:    state_d.rdData = state_q.supplyMsbHeld;
        `ADDR_DIE_MSB:       state_d.rdData = state_q.dieMsbHeld;
        default:             state_d.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= '{statusFirst:   `RST_STATUS, // R14
                   statusSecond:  `RST_STATUS, // R14
                   condFirst:     `RST_STATUS,
                   condSecond:    `RST_STATUS,
                   dieTemp:       `RST_RESULT, // R14
                   supply:        `RST_RESULT, // R14
                   dieMsbHeld:    `RST_MSB,
                   supplyMsbHeld: `RST_MSB,
                   frz:           lsr_pkg::MSB_FREE,
                   rdData:        `RST_LOW_BITS,
                   intActive:     1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign regRdData = state_q.rdData;
  assign intActive = state_q.intActive;
  assign msbFrozen = (state_q.frz == lsr_pkg::MSB_FROZEN);

endmodule : limit_status_and_result_lsbs

// ==== rtl/lsr_pkg.sv ====
package lsr_pkg;

  typedef enum logic [3:0] {
    CH_DIE    = 4'b0000,
    CH_EXT_A1 = 4'b0001,
    CH_A2     = 4'b0010,
    CH_A3     = 4'b0011,
    CH_A4     = 4'b0100,
    CH_A5     = 4'b0101,
    CH_A6     = 4'b0110,
    CH_A7     = 4'b0111,
    CH_A8     = 4'b1000,
    CH_SUPPLY = 4'b1001
  } chan_t;

  typedef enum logic [0:0] {
    MSB_FREE   = 1'b0,
    MSB_FROZEN = 1'b1
  } freeze_t;

  typedef struct packed {
    logic        valid;
    chan_t       chan;
    logic        aboveHigh;
    logic        atOrBelowLow;
  } cmp_state_t;

  typedef struct packed {
    logic [7:0] statusFirst;
    logic [7:0] statusSecond;
    logic [7:0] condFirst;
    logic [7:0] condSecond;
    logic [9:0] dieTemp;
    logic [9:0] supply;
    logic [7:0] dieMsbHeld;
    logic [7:0] supplyMsbHeld;
    freeze_t    frz;
    logic [7:0] rdData;
    logic       intActive;
  } top_state_t;

endpackage : lsr_pkg

// ==== rtl/lsr_regs.svh ====
`ifndef LSR_REGS_SVH
`define LSR_REGS_SVH

// Register offsets on the serial register port
`define ADDR_STATUS_FIRST   8'h00
`define ADDR_STATUS_SECOND  8'h01
`define ADDR_LOW_BITS       8'h03
`define ADDR_SUPPLY_MSB     8'h06
`define ADDR_DIE_MSB        8'h07

// Power-up values
`define RST_STATUS          8'h00
`define RST_LOW_BITS        8'h00
`define RST_RESULT          10'h000
`define RST_MSB             8'h00

// Status register 1 bit positions
`define S1_DIE_HIGH         0
`define S1_DIE_LOW          1
`define S1_PAIR_HIGH        2
`define S1_EXT_LOW          3
`define S1_DIODE_FAULT      4
`define S1_ANALOG_INPUT_TWO             5
// Status register 2 bit positions
`define S2_ANALOG_INPUT_FIVE             0
`define S2_SUPPLY           4
// Defined bits of status register 2, upper three reserved
`define S2_DEFINED_MASK     8'h1f

// Low-order result register field positions
`define LB_DIE_LSB          0
`define LB_SUPPLY_LSB       2

// Result and limit widths
`define RESULT_W            10
`define LIMIT_W             8
`define CHAN_COUNT          10

// Configuration 1 bits 2:1 value selecting the external sensor pair
`define CFG_PAIR_EXT        2'h0

`endif

// ==== tb/host_model.sv ====
`timescale 1ns/1ps

module host_model (
  // Clock
  input wire logic       sys_clk,
  // Register read port
  output logic           regRd,
  output logic [7:0]     regAddr,
  input wire logic [7:0] regRdData
);
  initial begin
    regRd = 1'b0;
    regAddr = 8'h00;
  end

  // Address is scrambled once released so a stale value never looks valid
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    regRd = 1'b1;
    regAddr = a;
    @(negedge sys_clk);
    regRd = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask : rd
endmodule : host_model

// ==== tb/limit_status_and_result_lsbs_bench.sv ====
`timescale 1ns/1ps

module limit_status_and_result_lsbs_bench;
  logic            sys_clk     = 1'b0;
  logic            arst_n      = 1'b0;
  logic            convValid   = 1'b0;
  lsr_pkg::chan_t  convChan    = lsr_pkg::CH_DIE;
  logic [9:0]      convResult  = 10'h000;
  logic            diodeFault  = 1'b0;
  logic [9:0][7:0] limHigh     = {10{8'h80}};
  logic [9:0][7:0] limLow      = {10{8'h10}};
  logic [7:0]      maskFirst   = 8'h00;
  logic [7:0]      maskSecond  = 8'h00;
  logic [1:0]      pairSel     = 2'h0;
  logic            softReset   = 1'b0;
  logic            regRd;
  logic [7:0]      regAddr;
  logic [7:0]      regRdData;
  logic            intActive;
  logic            msbFrozen;
  int              fails       = 0;
  int              checks_done = 0;

  limit_status_and_result_lsbs dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .convValid(convValid), .convChan(convChan),
    .convResult(convResult), .diodeFault(diodeFault), .limHigh(limHigh), .limLow(limLow),
    .maskFirst(maskFirst), .maskSecond(maskSecond), .pairSel(pairSel),
    .softReset(softReset), .regRd(regRd), .regAddr(regAddr), .regRdData(regRdData),
    .intActive(intActive), .msbFrozen(msbFrozen)
  );

  host_model host_u (
    .sys_clk(sys_clk), .regRd(regRd), .regAddr(regAddr), .regRdData(regRdData)
  );

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic summarize;
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    check(d, exp);
  endtask : rdChk

  // Leaves two idle cycles so the flag pipeline has settled on return
  task automatic conv(input lsr_pkg::chan_t ch, input logic [9:0] res);
    @(negedge sys_clk);
    convValid = 1'b1;
    convChan = ch;
    convResult = res;
    @(negedge sys_clk);
    convValid = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : conv

  task automatic tPowerUp;
    rdChk(8'h00, 8'h00);
    rdChk(8'h01, 8'h00);
    rdChk(8'h03, 8'h00);
  endtask : tPowerUp

  task automatic tDie;
    conv(lsr_pkg::CH_DIE, {8'h21, 2'b11});
    conv(lsr_pkg::CH_DIE, {8'h05, 2'b00});
    check({7'h00, intActive}, 8'h01);
    rdChk(8'h00, 8'h03);
    rdChk(8'h00, 8'h02);
    conv(lsr_pkg::CH_DIE, {8'h10, 2'b01});
    rdChk(8'h03, 8'h01);
    rdChk(8'h00, 8'h02);
    rdChk(8'h00, 8'h00);
  endtask : tDie

  task automatic tAin;
    pairSel = 2'h1;
    for (int i = 2; i <= 8; i++) begin
      conv(lsr_pkg::chan_t'(i), (i == 8) ? 10'h040 : 10'h204);
    end
    conv(lsr_pkg::CH_SUPPLY, 10'h20a);
    rdChk(8'h00, 8'he0);
    rdChk(8'h01, 8'h1f);
    rdChk(8'h03, 8'h09);
    maskFirst = 8'hff;
    maskSecond = 8'hff;
    repeat (4) @(negedge sys_clk);
    check({7'h00, intActive}, 8'h00);
    maskFirst = 8'h00;
    maskSecond = 8'h00;
    repeat (2) @(negedge sys_clk);
    check({7'h00, intActive}, 8'h01);
  endtask : tAin

  task automatic tSoft;
    @(negedge sys_clk);
    softReset = 1'b1;
    @(negedge sys_clk);
    softReset = 1'b0;
    rdChk(8'h00, 8'h00);
    rdChk(8'h01, 8'h00);
  endtask : tSoft

  task automatic tExt;
    pairSel = 2'h0;
    conv(lsr_pkg::CH_EXT_A1, {8'h11, 2'b00});
    conv(lsr_pkg::CH_EXT_A1, {8'hf0, 2'b00});
    diodeFault = 1'b1;
    repeat (2) @(negedge sys_clk);
    rdChk(8'h00, 8'h1c);
    diodeFault = 1'b0;
    pairSel = 2'h1;
    conv(lsr_pkg::CH_EXT_A1, {8'hf0, 2'b00});
    rdChk(8'h00, 8'h1c);
    rdChk(8'h00, 8'h04);
  endtask : tExt

  task automatic tFreeze;
    logic [7:0] d;
    host_u.rd(8'h07, d);
    check({7'h00, msbFrozen}, 8'h00);
    conv(lsr_pkg::CH_SUPPLY, 10'h155);
    rdChk(8'h03, 8'h05);
    check({7'h00, msbFrozen}, 8'h01);
    conv(lsr_pkg::CH_SUPPLY, 10'h2aa);
    rdChk(8'h06, 8'h55);
    rdChk(8'h06, 8'haa);
  endtask : tFreeze

  initial begin
    limHigh[0] = 8'h20;
    limLow[0] = 8'h05;
    limHigh[1] = 8'h10;
    limLow[1] = 8'h00;
    repeat (4) @(negedge sys_clk);
    arst_n = 1'b1;
    tPowerUp;
    tDie;
    tAin;
    tSoft;
    tExt;
    tFreeze;
    summarize;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    summarize;
  end
endmodule : limit_status_and_result_lsbs_bench

// ==== tb/lsr_chk.sv ====
`timescale 1ns/1ps

module lsr_chk (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       arst_n,
  // Watched inputs
  input wire logic       convValid,
  input wire logic       diodeFault,
  input wire logic [7:0] maskFirst,
  input wire logic [7:0] maskSecond,
  input wire logic       softReset,
  input wire logic       regRd,
  input wire logic [7:0] regAddr,
  // Watched outputs
  input wire logic [7:0] regRdData,
  input wire logic       intActive,
  input wire logic       msbFrozen
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  wire lowRd = regRd && regAddr == 8'h03;
  wire msbRd = regRd && (regAddr == 8'h06 || regAddr == 8'h07);

  status2_resv_a: assert property (
    regRd && regAddr == 8'h01 |=> regRdData[7:5] == 3'h0) else $error("status 2 spare bits set");
  low_resv_a: assert property (
    lowRd |=> regRdData[7:4] == 4'h0) else $error("low-order spare bits set");
  freeze_set_a: assert property (
    lowRd && !msbFrozen |=> msbFrozen) else $error("low-order read did not freeze");
  freeze_release_a: assert property (
    msbRd && msbFrozen |=> !msbFrozen) else $error("upper read did not release");
  stay_frozen_a: assert property (
    msbFrozen && !msbRd |=> msbFrozen) else $error("freeze dropped on its own");
  stay_free_a: assert property (
    !msbFrozen && !lowRd |=> !msbFrozen) else $error("freeze without low-order read");
  soft_clear_a: assert property (
    softReset && !convValid && !$past(convValid) && !$past(convValid, 2)
    && !diodeFault && !$past(diodeFault) |=> !intActive) else $error("soft reset left flags");
  int_masked_a: assert property (
    (&maskFirst && &maskSecond) [*3] |-> !intActive) else $error("masked flag raised output");
endmodule : lsr_chk

bind limit_status_and_result_lsbs lsr_chk chk_u (
  .sys_clk(sys_clk), .arst_n(arst_n), .convValid(convValid), .diodeFault(diodeFault),
  .maskFirst(maskFirst), .maskSecond(maskSecond), .softReset(softReset), .regRd(regRd),
  .regAddr(regAddr), .regRdData(regRdData), .intActive(intActive), .msbFrozen(msbFrozen)
);
